// ===== verilog/sac_pkg.sv
// package for the sar converter control block: register offsets, field layout, reset values
// assumes an 8-bit special-function register port driven by the core on the system clock
package sac_pkg;
   localparam logic [7:0] CLK_CFG_ADDR = 8'h_bc;
   localparam logic [7:0] RES_LOW_ADDR = 8'h_be;
   localparam logic [7:0] CTRL_ADDR = 8'h_e8;
   localparam logic [7:0] CLK_CFG_RESET = 8'h_f8;
   localparam logic [7:0] RES_LOW_RESET = 8'h_00;
   localparam logic [7:0] CTRL_RESET = 8'h_00;
   localparam int DIV_LSB = 3;
   localparam int DIV_W = 5;
   localparam int EN_BIT = 7;
   localparam int TM_BIT = 6;
   localparam int DONE_BIT = 5;
   localparam int BUSY_BIT = 4;
   localparam int CM_LSB = 2;
   localparam int WIN_BIT = 1;
   localparam int LJ_BIT = 0;
   localparam int TRACK_CLKS = 3;
   localparam int CONV_CLKS = 10;
   localparam logic [1:0] CM_WRITE = 2'h_0;
   localparam logic [1:0] CM_TIMER3 = 2'h_1;
   localparam logic [1:0] CM_EXT = 2'h_2;
   localparam logic [1:0] CM_TIMER2 = 2'h_3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sac_sfr_t;

   typedef struct packed {
      logic timer2_ovf;
      logic timer3_ovf;
      logic ext_start;
   } sac_trig_t;
endpackage

// ===== verilog/sac_ctrl.sv
// sar converter control: clock divider, start sequencing, result justification, control bits
// assumes sfr accesses are single-cycle strobes and trigger inputs are synchronous to clk
`timescale 1ns/1ps

// Operation
// - The sar clock is the system clock divided by the five-bit divider field plus one.
// - The divider sits in bits seven to three of the clock register, which resets to all ones there and zeros below.
// - The three low bits of the clock register read zero and ignore writes.
// - With right justification the low result register shows result bits seven to zero.
// - With left justification the low result register shows result bits one and zero in bits seven and six and zeros below.
// - The done flag is set when busy falls at the end of a conversion.
// - In continuous tracking with start mode two a conversion begins on a rising edge of the external start input.
// - In low-power tracking with start mode one tracking begins on timer three overflow, lasts three sar clocks, then converts.
module sac_ctrl #(
   parameter int RES_W = 10
)
(
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire sac_pkg::sac_sfr_t sfr, // register access strobes
   output logic [7:0] sfr_rdata, // read data
   input wire sac_pkg::sac_trig_t trig, // start sources
   input wire logic [RES_W-1:0] sar_result, // result from analog core
   input wire logic window_hit, // window comparator event
   output logic sar_clk_en, // one-cycle sar clock enable
   output logic conv_busy, // conversion in progress
   output logic track_active, // sampling switch closed
   output logic powered // converter enabled
);
   if (RES_W != 10)
   begin
      $error("sac_ctrl supports only a 10-bit result");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sac_state_t;

   logic [7:0] clk_cfg_r;
   logic [7:0] ctrl_r;
   logic [7:0] res_low_r;
   logic [sac_pkg::DIV_W-1:0] div_cnt_r;
   logic [3:0] step_r;
   logic ext_d_r;
   sac_state_t state_r;
   logic [2:0] trk_seen_r;

   logic [4:0] divider;
   logic enable, tm, ext_rise, start_now, track_start, conv_end, wr_busy;
   logic [1:0] cm;

   assign divider = clk_cfg_r[sac_pkg::DIV_LSB +: sac_pkg::DIV_W];
   assign enable = ctrl_r[sac_pkg::EN_BIT];
   assign tm = ctrl_r[sac_pkg::TM_BIT];
   assign cm = ctrl_r[sac_pkg::CM_LSB +: 2];
   assign ext_rise = trig.ext_start & ~ext_d_r;
   assign wr_busy = sfr.wr && sfr.addr == sac_pkg::CTRL_ADDR && sfr.wdata[sac_pkg::BUSY_BIT];

   // start decode per tracking mode
   always_comb
   begin
      start_now = 1'b0;
      track_start = 1'b0;
      if (enable && state_r == ST_IDLE)
      begin
         unique case (cm)
            sac_pkg::CM_WRITE: if (tm) track_start = wr_busy; else start_now = wr_busy;
            sac_pkg::CM_TIMER3: if (tm) track_start = trig.timer3_ovf; else start_now = trig.timer3_ovf;
            sac_pkg::CM_EXT: start_now = ext_rise;
            sac_pkg::CM_TIMER2: if (tm) track_start = trig.timer2_ovf; else start_now = trig.timer2_ovf;
         endcase
      end
   end

   // sar clock divider: period of divider+1 system clocks
   always_ff @(posedge clk)
   begin
      if (srst || !enable || div_cnt_r == divider)
         div_cnt_r <= '0;
      else
         div_cnt_r <= div_cnt_r + 5'h_1;
   end
   assign sar_clk_en = enable && div_cnt_r == divider;

   always_ff @(posedge clk)
   begin
      if (srst)
         ext_d_r <= 1'b0;
      else
         ext_d_r <= trig.ext_start;
   end

   // sequencer: a tracking start tracks three sar clocks then converts, other starts convert at once
   always_ff @(posedge clk)
   begin
      if (srst || !enable)
      begin
         state_r <= ST_IDLE;
         step_r <= '0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               step_r <= '0;
               if (track_start)
                  state_r <= ST_TRACK;
               else if (start_now)
                  state_r <= ST_CONV;
            end
            ST_TRACK:
               if (sar_clk_en)
               begin
                  if (step_r == 4'(sac_pkg::TRACK_CLKS - 1))
                  begin
                     state_r <= ST_CONV;
                     step_r <= '0;
                  end
                  else
                     step_r <= step_r + 4'h_1;
               end
            ST_CONV:
               if (sar_clk_en)
               begin
                  if (step_r == 4'(sac_pkg::CONV_CLKS - 1))
                     state_r <= ST_IDLE;
                  else
                     step_r <= step_r + 4'h_1;
               end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end
   assign conv_end = state_r == ST_CONV && sar_clk_en && step_r == 4'(sac_pkg::CONV_CLKS - 1);

   // sar clock pulses seen in the current tracking phase, read only by the length check
   always_ff @(posedge clk)
   begin
      if (srst || state_r != ST_TRACK)
         trk_seen_r <= '0;
      else if (sar_clk_en)
         trk_seen_r <= trk_seen_r + 3'h_1;
   end

   // clock configuration register
   always_ff @(posedge clk)
   begin
      if (srst)
         clk_cfg_r <= sac_pkg::CLK_CFG_RESET;
      else if (sfr.wr && sfr.addr == sac_pkg::CLK_CFG_ADDR)
         clk_cfg_r <= {sfr.wdata[7:3], 3'h_0};
   end

   // control register: done and window flags are set by hardware, set wins over a clear
   always_ff @(posedge clk)
   begin
      if (srst)
         ctrl_r <= sac_pkg::CTRL_RESET;
      else
      begin
         if (sfr.wr && sfr.addr == sac_pkg::CTRL_ADDR)
            ctrl_r <= {sfr.wdata[7:5], 1'b0, sfr.wdata[3:0]};
         if (conv_end)
            ctrl_r[sac_pkg::DONE_BIT] <= 1'b1;
         if (window_hit && enable)
            ctrl_r[sac_pkg::WIN_BIT] <= 1'b1;
      end
   end

   // low result byte, captured right justified and justified only when read
   always_ff @(posedge clk)
   begin
      if (srst)
         res_low_r <= sac_pkg::RES_LOW_RESET;
      else if (conv_end)
         res_low_r <= sar_result[7:0];
      else if (sfr.wr && sfr.addr == sac_pkg::RES_LOW_ADDR)
         res_low_r <= sfr.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         sfr_rdata <= 8'h_00;
      else if (sfr.rd)
      begin
         unique case (sfr.addr)
            sac_pkg::CLK_CFG_ADDR: sfr_rdata <= {divider, 3'h_0};
            sac_pkg::CTRL_ADDR: sfr_rdata <= {ctrl_r[7:5], conv_busy, ctrl_r[3:0]};
            sac_pkg::RES_LOW_ADDR:
               if (ctrl_r[sac_pkg::LJ_BIT])
                  sfr_rdata <= {res_low_r[1:0], 6'h_00};
               else
                  sfr_rdata <= res_low_r;
            default: sfr_rdata <= 8'h_00;
         endcase
      end
   end

   assign conv_busy = state_r != ST_IDLE;
   assign track_active = enable && (state_r == ST_TRACK || (state_r == ST_IDLE && !tm
      && !(cm == sac_pkg::CM_EXT && trig.ext_start)));
   assign powered = enable;

   chk_done_on_end: assert property (@(posedge clk) disable iff (srst)
      conv_end |=> ctrl_r[sac_pkg::DONE_BIT]) else $error("done flag not set at conversion end");
   chk_no_start_off: assert property (@(posedge clk) disable iff (srst)
      !enable |=> !conv_busy) else $error("busy while disabled");
   chk_cfg_low_zero: assert property (@(posedge clk) disable iff (srst)
      sfr.wr && sfr.addr == sac_pkg::CLK_CFG_ADDR && sfr.wdata[2:0] != 3'h_0 |=> clk_cfg_r[2:0] == 3'h_0)
      else $error("clock config low bits set");
   chk_div_period: assert property (@(posedge clk) disable iff (srst)
      sar_clk_en && divider == 5'h_1 ##1 enable && $stable(clk_cfg_r)
      |-> !sar_clk_en ##1 (!enable || !$stable(clk_cfg_r) || sar_clk_en))
      else $error("sar clock period wrong");
   chk_ext_start: assert property (@(posedge clk) disable iff (srst)
      enable && state_r == ST_IDLE && cm == sac_pkg::CM_EXT && trig.ext_start && !$past(trig.ext_start)
      |=> state_r == ST_CONV) else $error("external start missed");
   chk_track_len: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_TRACK ##1 state_r == ST_CONV |-> trk_seen_r == 3'(sac_pkg::TRACK_CLKS))
      else $error("tracking phase length wrong");
   chk_lj_read: assert property (@(posedge clk) disable iff (srst)
      sfr.rd && sfr.addr == sac_pkg::RES_LOW_ADDR && ctrl_r[sac_pkg::LJ_BIT] |=> sfr_rdata[5:0] == 6'h_00)
      else $error("left justified low bits not zero");
   chk_rj_read: assert property (@(posedge clk) disable iff (srst)
      sfr.rd && sfr.addr == sac_pkg::RES_LOW_ADDR && !ctrl_r[sac_pkg::LJ_BIT] |=> sfr_rdata == $past(res_low_r))
      else $error("right justified read wrong");
   chk_cfg_reset: assert property (@(posedge clk)
      srst |=> clk_cfg_r == sac_pkg::CLK_CFG_RESET) else $error("clock config reset wrong");
endmodule

// ===== bench/tb.sv
// testbench for the sar converter control block: register tasks and sequenced tests
// assumes the core strobes sfr accesses for one cycle and the design asserts its own rules
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   sac_pkg::sac_sfr_t sfr = '0;
   sac_pkg::sac_trig_t trig = '0;
   logic [9:0] sar_result = 10'h_000;
   logic [7:0] sfr_rdata;
   logic sar_clk_en, conv_busy, track_active, powered;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int cnt;
   sac_ctrl #(.RES_W(10)) dut (.clk(clk), .srst(srst), .sfr(sfr), .sfr_rdata(sfr_rdata), .trig(trig),
      .sar_result(sar_result), .window_hit(1'b0), .sar_clk_en(sar_clk_en), .conv_busy(conv_busy),
      .track_active(track_active), .powered(powered));
   always #5 clk = ~clk;
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_total = err_total + 1;
         finish_test();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         err_total = err_total + 1;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfr.wr = 1'b1;
      sfr.addr = a;
      sfr.wdata = d;
      tick(1);
      sfr.wr = 1'b0;
   endtask
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      sfr.rd = 1'b1;
      sfr.addr = a;
      tick(1);
      sfr.rd = 1'b0;
      tick(1);
      check(sfr_rdata, exp);
   endtask
   task automatic wait_busy(input logic v);
      int i;
      for (i = 0; i < 200 && conv_busy !== v; i++)
         tick(1);
      check({7'h_00, conv_busy}, {7'h_00, v});
   endtask
   task automatic count_track(input int n);
      cnt = 0;
      repeat (60)
      begin
         cnt = cnt + int'(sar_clk_en && track_active);
         tick(1);
      end
      check(8'(cnt), 8'(n));
   endtask
   initial
   begin
      tick(12);
      srst = 1'b0;
      sfr_rd(sac_pkg::CLK_CFG_ADDR, 8'h_f8);
      sfr_rd(sac_pkg::RES_LOW_ADDR, 8'h_00);
      sfr_rd(sac_pkg::CTRL_ADDR, 8'h_00);
      sfr_rd(8'h_55, 8'h_00);
      sfr_wr(sac_pkg::CLK_CFG_ADDR, 8'h_ff);
      sfr_rd(sac_pkg::CLK_CFG_ADDR, 8'h_f8);
      sfr_wr(sac_pkg::CLK_CFG_ADDR, 8'h_0f);
      sfr_rd(sac_pkg::CLK_CFG_ADDR, 8'h_08);
      $display("config register test done");
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_10);
      tick(5);
      check({6'h_00, conv_busy, powered}, 8'h_00);
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_80);
      check({7'h_00, powered}, 8'h_01);
      cnt = 0;
      repeat (20)
      begin
         cnt = cnt + int'(sar_clk_en);
         tick(1);
      end
      check(8'(cnt), 8'h_0a);
      $display("divider test done");
      sar_result = 10'h_2a5;
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_90);
      wait_busy(1'b1);
      wait_busy(1'b0);
      tick(1);
      sfr_rd(sac_pkg::CTRL_ADDR, 8'h_a0);
      sfr_rd(sac_pkg::RES_LOW_ADDR, 8'h_a5);
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_81);
      sfr_rd(sac_pkg::RES_LOW_ADDR, 8'h_40);
      $display("software start test done");
      sar_result = 10'h_17e;
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_89);
      tick(4);
      check({7'h_00, conv_busy}, 8'h_00);
      trig.ext_start = 1'b1;
      wait_busy(1'b1);
      wait_busy(1'b0);
      trig.ext_start = 1'b0;
      tick(1);
      sfr_rd(sac_pkg::RES_LOW_ADDR, 8'h_80);
      $display("external start test done");
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_c4);
      trig.timer3_ovf = 1'b1;
      tick(1);
      trig.timer3_ovf = 1'b0;
      count_track(3);
      sfr_rd(sac_pkg::CTRL_ADDR, 8'h_e4);
      sfr_rd(sac_pkg::RES_LOW_ADDR, 8'h_7e);
      $display("timer tracking test done");
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_c0);
      tick(1);
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_d0);
      count_track(3);
      sfr_rd(sac_pkg::CTRL_ADDR, 8'h_e0);
      $display("write tracking test done");
      sfr_wr(sac_pkg::CTRL_ADDR, 8'h_8c);
      tick(1);
      check({7'h_00, track_active}, 8'h_01);
      trig.timer2_ovf = 1'b1;
      tick(1);
      trig.timer2_ovf = 1'b0;
      check({7'h_00, track_active}, 8'h_00);
      wait_busy(1'b1);
      wait_busy(1'b0);
      $display("timer start test done");
      srst = 1'b1;
      tick(2);
      srst = 1'b0;
      check({7'h_00, powered}, 8'h_00);
      sfr_rd(sac_pkg::CLK_CFG_ADDR, 8'h_f8);
      sfr_rd(sac_pkg::CTRL_ADDR, 8'h_00);
      $display("second reset test done");
      finish_test();
   end
endmodule
